// [design/scd_map.svh]
// Constants of the start command decoder: offsets, fields, resets, timing
`ifndef SCD_MAP_SVH
`define SCD_MAP_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define SCD_HALT_OFF 8'h00
`define SCD_FSEL_OFF 8'h04
`define SCD_RSEL_OFF 8'h08
`define SCD_G0SEL_OFF 8'h0C
`define SCD_G1SEL_OFF 8'h10
`define SCD_CTRL_OFF 8'h14
`define SCD_STAT_OFF 8'h18

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define SCD_CTRL_JOG_EN 0
`define SCD_HALT_DECEL_DIRECT 16'h270F
`define SCD_HALT_DECEL_STARTDIR 16'h22B8
`define SCD_HALT_COAST_MAX 16'h0064
`define SCD_HALT_OFS_MIN 16'h03E8
`define SCD_HALT_OFS_MAX 16'h044C
`define SCD_HALT_RST 16'h270F
`define SCD_FN_HOLD 8'h19
`define SCD_FN_FWD 8'h3C
`define SCD_FN_REV 8'h3D
`define SCD_FN_NONE 8'hFF

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define SCD_CLK_HZ 25000000
`define SCD_TICK_S 1
`define SCD_SEC_CYCLES (`SCD_TICK_S * `SCD_CLK_HZ)

`endif

// [design/scd_pkg.sv]
// Types shared by the start command decoder
package scd_pkg;

	typedef struct packed {
		logic jog;
		logic shutoff;
		logic hold;
		logic gen1;
		logic gen0;
		logic rev;
		logic fwd;
	} scd_term_t;

	typedef struct packed {
		logic coast;
		logic decel;
		logic rev;
		logic run;
	} scd_cmd_t;

	typedef enum logic [2:0] {
		SCD_IDLE,
		SCD_RUN,
		SCD_WAIT,
		SCD_DECEL,
		SCD_COAST
	} scd_state_t;

endpackage

// [design/scd_sync.sv]
// Two-stage synchroniser for the terminal inputs
`timescale 1ns/100ps
`default_nettype none
module scd_sync #(
	parameter int W = 7
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] q_next;

	always_comb begin
		meta_next = d;
		q_next = meta_reg;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= '0;
			q <= '0;
		end else begin
			meta_reg <= meta_next;
			q <= q_next;
		end
	end

	a_sync_two_stage: assert property (@(posedge pclk) disable iff (!presetn)
		$past(presetn, 2) |-> q == $past(d, 2))
		else $error("sync delay not two");
endmodule
`default_nettype wire

// [design/scd_delay.sv]
// Whole-second delay timer for the coast stop
`include "scd_map.svh"
`timescale 1ns/100ps
`default_nettype none
module scd_delay #(
	parameter int unsigned SEC_CYCLES = `SCD_SEC_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic load,
	input wire logic cancel,
	input wire logic [6:0] secs,
	output logic done
);
	logic busy_reg, busy_next;
	logic done_next;
	logic [6:0] sec_reg, sec_next;
	logic [24:0] sub_reg, sub_next;

	always_comb begin
		busy_next = busy_reg;
		done_next = done;
		sec_next = sec_reg;
		sub_next = sub_reg;
		if (cancel) begin
			busy_next = 1'b0;
			done_next = 1'b0;
		end else if (load) begin
			busy_next = 1'b1;
			done_next = 1'b0;
			sec_next = secs;
			sub_next = '0;
		end else if (busy_reg) begin
			if (sec_reg == 7'h00) begin
				busy_next = 1'b0;
				done_next = 1'b1;
			end else if (sub_reg == 25'(SEC_CYCLES - 1)) begin
				sub_next = '0;
				sec_next = sec_reg - 7'h01;
			end else begin
				sub_next = sub_reg + 25'h0000001;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_reg <= 1'b0;
			done <= 1'b0;
			sec_reg <= '0;
			sub_reg <= '0;
		end else begin
			busy_reg <= busy_next;
			done <= done_next;
			sec_reg <= sec_next;
			sub_reg <= sub_next;
		end
	end

	a_zero_delay_done: assert property (@(posedge pclk) disable iff (!presetn)
		load && !cancel && secs == 7'h00 ##1 !cancel |=> done)
		else $error("zero delay not done in two cycles");
endmodule
`default_nettype wire

// [design/scd_top.sv]
// Start command decoder: terminal decode, self-hold, stop method, APB
//
// The APB register port and the register addresses were chosen for this implementation.
`include "scd_map.svh"
`timescale 1ns/100ps
`default_nettype none
module scd_top import scd_pkg::*; #(
	parameter int unsigned SEC_CYCLES = `SCD_SEC_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire scd_term_t term_in,
	input wire logic stopped_in,
	output scd_cmd_t cmd_out,
	output logic drive_enable
);

	// ---------------------------------------------------------------
	// Setting decode
	// ---------------------------------------------------------------
	function automatic logic scd_is_coast(input logic [15:0] s);
		return (s <= `SCD_HALT_COAST_MAX) ||
			(s >= `SCD_HALT_OFS_MIN && s <= `SCD_HALT_OFS_MAX);
	endfunction

	function automatic logic scd_is_direct(input logic [15:0] s);
		return (s == `SCD_HALT_DECEL_DIRECT) || (s <= `SCD_HALT_COAST_MAX);
	endfunction

	function automatic logic scd_is_valid(input logic [15:0] s);
		return scd_is_coast(s) || (s == `SCD_HALT_DECEL_DIRECT) ||
			(s == `SCD_HALT_DECEL_STARTDIR);
	endfunction

	function automatic logic [6:0] scd_coast_secs(input logic [15:0] s);
		logic [15:0] d;
		d = s - `SCD_HALT_OFS_MIN;
		return (s <= `SCD_HALT_COAST_MAX) ? s[6:0] : d[6:0];
	endfunction

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [15:0] halt_method_setting_reg, halt_next;
	logic [7:0] fwd_sel_reg, fwd_sel_next;
	logic [7:0] rev_sel_reg, rev_sel_next;
	logic [7:0] g0_sel_reg, g0_sel_next;
	logic [7:0] g1_sel_reg, g1_sel_next;
	logic jog_en_reg, jog_en_next;
	logic [31:0] prdata_next;
	logic pready_next, pslverr_next;
	logic wr_go, setup;
	logic [31:0] status;
	logic latched_reg, latched_next;
	logic lrev_reg, lrev_next;
	scd_state_t state_reg, state_next;

	assign setup = psel && !penable;
	assign wr_go = psel && penable && pready && pwrite;
	assign status = {22'h000000, jog_en_reg, lrev_reg, latched_reg,
		cmd_out.coast, cmd_out.decel, cmd_out.rev, cmd_out.run,
		drive_enable, 2'h0};

	always_comb begin
		halt_next = halt_method_setting_reg;
		fwd_sel_next = fwd_sel_reg;
		rev_sel_next = rev_sel_reg;
		g0_sel_next = g0_sel_reg;
		g1_sel_next = g1_sel_reg;
		jog_en_next = jog_en_reg;
		prdata_next = prdata;
		pready_next = setup;
		pslverr_next = 1'b0;
		if (setup) begin
			prdata_next = 32'h00000000;
			unique case (paddr)
				`SCD_HALT_OFF: begin
					prdata_next = {16'h0000, halt_method_setting_reg};
					pslverr_next = pwrite && !scd_is_valid(pwdata[15:0]);
				end
				`SCD_FSEL_OFF: prdata_next = {24'h000000, fwd_sel_reg};
				`SCD_RSEL_OFF: prdata_next = {24'h000000, rev_sel_reg};
				`SCD_G0SEL_OFF: begin
					prdata_next = {24'h000000, g0_sel_reg};
					pslverr_next = pwrite && (pwdata[7:0] == `SCD_FN_FWD ||
						pwdata[7:0] == `SCD_FN_REV);
				end
				`SCD_G1SEL_OFF: begin
					prdata_next = {24'h000000, g1_sel_reg};
					pslverr_next = pwrite && (pwdata[7:0] == `SCD_FN_FWD ||
						pwdata[7:0] == `SCD_FN_REV);
				end
				`SCD_CTRL_OFF: prdata_next = {31'h00000000, jog_en_reg};
				`SCD_STAT_OFF: begin
					prdata_next = status;
					pslverr_next = pwrite;
				end
				default: pslverr_next = 1'b1;
			endcase
		end
		if (wr_go && !pslverr) begin
			unique case (paddr)
				`SCD_HALT_OFF: halt_next = pwdata[15:0];
				`SCD_FSEL_OFF: fwd_sel_next = pwdata[7:0];
				`SCD_RSEL_OFF: rev_sel_next = pwdata[7:0];
				`SCD_G0SEL_OFF: g0_sel_next = pwdata[7:0];
				`SCD_G1SEL_OFF: g1_sel_next = pwdata[7:0];
				`SCD_CTRL_OFF: jog_en_next = pwdata[`SCD_CTRL_JOG_EN];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_method_setting_reg <= `SCD_HALT_RST;
			fwd_sel_reg <= `SCD_FN_FWD;
			rev_sel_reg <= `SCD_FN_REV;
			g0_sel_reg <= `SCD_FN_NONE;
			g1_sel_reg <= `SCD_FN_NONE;
			jog_en_reg <= 1'b0;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			halt_method_setting_reg <= halt_next;
			fwd_sel_reg <= fwd_sel_next;
			rev_sel_reg <= rev_sel_next;
			g0_sel_reg <= g0_sel_next;
			g1_sel_reg <= g1_sel_next;
			jog_en_reg <= jog_en_next;
			prdata <= prdata_next;
			pready <= pready_next;
			pslverr <= pslverr_next;
		end
	end

	// ---------------------------------------------------------------
	// Terminal decode
	// ---------------------------------------------------------------
	scd_term_t sync_q;
	logic fwd_s, rev_s, jog_ok, hold_eff;
	logic direct, coast, self_hold;
	logic fwd_q_reg, rev_q_reg, hold_q_reg;
	logic fwd_fall, rev_fall, hold_fall;

	scd_sync #(.W(7)) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(term_in),
		.q(sync_q)
	);

	assign fwd_s = (fwd_sel_reg == `SCD_FN_FWD) && sync_q.fwd;
	assign rev_s = (rev_sel_reg == `SCD_FN_REV) && sync_q.rev;
	assign jog_ok = sync_q.jog && jog_en_reg;
	assign hold_eff = !jog_ok && (sync_q.hold ||
		(g0_sel_reg == `SCD_FN_HOLD && sync_q.gen0) ||
		(g1_sel_reg == `SCD_FN_HOLD && sync_q.gen1));
	assign direct = scd_is_direct(halt_method_setting_reg);
	assign coast = scd_is_coast(halt_method_setting_reg);
	assign self_hold = hold_eff;
	assign fwd_fall = fwd_q_reg && !fwd_s;
	assign rev_fall = rev_q_reg && !rev_s;
	assign hold_fall = hold_q_reg && !hold_eff;

	// ---------------------------------------------------------------
	// Self-holding latch
	// ---------------------------------------------------------------
	always_comb begin
		latched_next = latched_reg;
		lrev_next = lrev_reg;
		if (!hold_eff) begin
			latched_next = 1'b0;
		end else if (fwd_fall) begin
			latched_next = 1'b1;
			lrev_next = direct ? 1'b0 : rev_s;
		end else if (rev_fall && direct) begin
			latched_next = 1'b1;
			lrev_next = 1'b1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latched_reg <= 1'b0;
			lrev_reg <= 1'b0;
			fwd_q_reg <= 1'b0;
			rev_q_reg <= 1'b0;
			hold_q_reg <= 1'b0;
		end else begin
			latched_reg <= latched_next;
			lrev_reg <= lrev_next;
			fwd_q_reg <= fwd_s;
			rev_q_reg <= rev_s;
			hold_q_reg <= hold_eff;
		end
	end

	// ---------------------------------------------------------------
	// Run request and stop method
	// ---------------------------------------------------------------
	logic run_req, dir_req, tmr_load, tmr_cancel, tmr_done;
	scd_cmd_t cmd_next;

	always_comb begin
		if (self_hold) begin
			run_req = latched_reg;
			dir_req = lrev_reg;
		end else if (direct) begin
			run_req = fwd_s ^ rev_s;
			dir_req = rev_s && !fwd_s;
		end else begin
			run_req = fwd_s;
			dir_req = rev_s;
		end
	end

	scd_delay #(.SEC_CYCLES(SEC_CYCLES)) u_delay (
		.pclk(pclk),
		.presetn(presetn),
		.load(tmr_load),
		.cancel(tmr_cancel),
		.secs(scd_coast_secs(halt_method_setting_reg)),
		.done(tmr_done)
	);

	always_comb begin
		state_next = state_reg;
		tmr_load = 1'b0;
		tmr_cancel = 1'b0;
		unique case (state_reg)
			SCD_IDLE: if (run_req) state_next = SCD_RUN;
			SCD_RUN: begin
				if (!run_req) begin
					if (hold_fall || !coast) begin
						state_next = SCD_DECEL;
					end else begin
						state_next = SCD_WAIT;
						tmr_load = 1'b1;
					end
				end
			end
			SCD_WAIT: begin
				if (run_req) begin
					state_next = SCD_RUN;
					tmr_cancel = 1'b1;
				end else if (tmr_done) begin
					state_next = SCD_COAST;
					tmr_cancel = 1'b1;
				end
			end
			SCD_DECEL, SCD_COAST: begin
				if (run_req) state_next = SCD_RUN;
				else if (stopped_in) state_next = SCD_IDLE;
			end
		endcase
		cmd_next.run = (state_next == SCD_RUN) || (state_next == SCD_WAIT);
		cmd_next.rev = (state_next == SCD_RUN) ? dir_req : cmd_out.rev;
		cmd_next.decel = state_next == SCD_DECEL;
		cmd_next.coast = state_next == SCD_COAST;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= SCD_IDLE;
			cmd_out <= '0;
			drive_enable <= 1'b0;
		end else begin
			state_reg <= state_next;
			cmd_out <= cmd_next;
			drive_enable <= !sync_q.shutoff;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	a_direct_forward: assert property (@(posedge pclk) disable iff (!presetn)
		!self_hold && direct && fwd_s && !rev_s |=> cmd_out.run && !cmd_out.rev)
		else $error("forward alone did not run forward");
	a_direct_both_stop: assert property (@(posedge pclk)
		disable iff (!presetn) state_reg == SCD_RUN && !self_hold && direct &&
		!coast && fwd_s && rev_s |=> cmd_out.decel && !cmd_out.run)
		else $error("both inputs did not stop");
	a_startdir_reverse: assert property (@(posedge pclk) disable iff (!presetn)
		!self_hold && !direct && fwd_s && rev_s |=> cmd_out.run && cmd_out.rev)
		else $error("start with direction not reverse");
	a_coast_wait: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == SCD_RUN && !run_req && !hold_fall && coast
		|=> state_reg == SCD_WAIT ##1 !cmd_out.decel)
		else $error("coast mode did not wait");
	a_decel_stop: assert property (@(posedge pclk) disable iff (!presetn)
		state_reg == SCD_RUN && !run_req && !coast |=> cmd_out.decel)
		else $error("decel mode did not decelerate");
	a_latch_on_fall: assert property (@(posedge pclk) disable iff (!presetn)
		hold_eff && direct && fwd_fall |=> latched_reg && !lrev_reg)
		else $error("start pulse not latched");
	a_hold_clears: assert property (@(posedge pclk) disable iff (!presetn)
		hold_fall && state_reg == SCD_RUN && !run_req
		|=> !latched_reg && cmd_out.decel)
		else $error("hold release did not clear and decel");
	a_jog_ignores: assert property (@(posedge pclk) disable iff (!presetn)
		jog_ok |-> !hold_eff)
		else $error("hold release seen during inching");
	a_shutoff_keeps: assert property (@(posedge pclk) disable iff (!presetn)
		sync_q.shutoff && hold_eff && latched_reg
		|=> !drive_enable && latched_reg)
		else $error("shutoff lost latch or kept output");
	a_gen_hold: assert property (@(posedge pclk) disable iff (!presetn)
		g0_sel_reg == `SCD_FN_HOLD && sync_q.gen0 && !jog_ok |-> hold_eff)
		else $error("code 25 terminal not routed");
endmodule
`default_nettype wire

// [tb/scd_switch_model.sv]
// Start switches and motor model facing the start command decoder
`timescale 1ns/100ps
`default_nettype none
module scd_switch_model import scd_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire scd_cmd_t cmd_out,
	output var scd_term_t term_in,
	output logic stopped_in
);
	int stop_cycles = 3;
	int spin_reg;

	initial term_in = '0;

	// ------------------------------------------------------------
	// Motor: comes to rest some cycles after a decel or coast
	// ------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			spin_reg <= 0;
			stopped_in <= 1'h1;
		end else if (cmd_out.run) begin
			spin_reg <= 0;
			stopped_in <= 1'h0;
		end else if (cmd_out.decel || cmd_out.coast) begin
			spin_reg <= spin_reg + 1;
			if (spin_reg >= stop_cycles) begin
				stopped_in <= 1'h1;
			end
		end
	end

	// ------------------------------------------------------------
	// Switch actions
	// ------------------------------------------------------------
	task automatic drive(input scd_term_t v);
		@(posedge pclk);
		term_in <= v;
	endtask

	// Momentary trigger: on for a few cycles, then off again
	task automatic pulse(input scd_term_t base, input scd_term_t start);
		drive(base | start);
		repeat (4) @(posedge pclk);
		drive(base);
	endtask
endmodule
`default_nettype wire

// [tb/start_command_decoder_tb.sv]
// Self-checking bench of the start command decoder
`include "scd_map.svh"
`timescale 1ns/100ps
`default_nettype none
module start_command_decoder_tb import scd_pkg::*;;
	localparam int SEC = 10;
	typedef struct packed {
		logic [15:0] halt;
		logic [1:0] fr;
		logic [1:0] ex;
		logic cm;
	} scd_row_t;
	scd_row_t rows [18] = '{
		'{16'h0000, 2'h2, 2'h2, 1'h1}, '{16'h03E8, 2'h2, 2'h2, 1'h1},
		'{16'h270F, 2'h0, 2'h0, 1'h0}, '{16'h270F, 2'h1, 2'h3, 1'h0},
		'{16'h270F, 2'h2, 2'h2, 1'h0}, '{16'h270F, 2'h3, 2'h0, 1'h0},
		'{16'h0003, 2'h0, 2'h0, 1'h1}, '{16'h0003, 2'h1, 2'h3, 1'h1},
		'{16'h0003, 2'h2, 2'h2, 1'h1}, '{16'h0003, 2'h3, 2'h0, 1'h1},
		'{16'h22B8, 2'h0, 2'h0, 1'h0}, '{16'h22B8, 2'h1, 2'h0, 1'h0},
		'{16'h22B8, 2'h2, 2'h2, 1'h0}, '{16'h22B8, 2'h3, 2'h3, 1'h0},
		'{16'h03EB, 2'h0, 2'h0, 1'h1}, '{16'h03EB, 2'h1, 2'h0, 1'h1},
		'{16'h03EB, 2'h2, 2'h2, 1'h1}, '{16'h03EB, 2'h3, 2'h3, 1'h1}};
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic drive_enable, stopped_in, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	scd_term_t term_in, t, hb;
	scd_cmd_t cmd_out;
	int mismatches = 0;
	int check_count = 0;
	int cycles = 0;

	scd_top #(.SEC_CYCLES(SEC)) uut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .term_in(term_in), .stopped_in(stopped_in),
		.cmd_out(cmd_out), .drive_enable(drive_enable));
	scd_switch_model sw (.pclk(pclk), .presetn(presetn),
		.cmd_out(cmd_out), .term_in(term_in), .stopped_in(stopped_in));

	initial begin
		pclk = 1'h0;
		forever #20 pclk = ~pclk;
	end

	// ------------------------------------------------------------
	// Compare, bus and wait helpers
	// ------------------------------------------------------------
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk_bit(input string nm, input logic x, input logic g);
		check_count++;
		if (g !== x) begin
			mismatches++;
			$display("BAD %s expected %b seen %b", nm, x, g);
		end
	endtask

	task automatic chk_word(input string nm, input logic [31:0] x,
		input logic [31:0] g);
		check_count++;
		if (g !== x) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, x, g);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do @(posedge pclk); while (pready !== 1'h1);
		q = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic x);
		apb(1'h1, a, d);
		chk_bit("pslverr", x, e);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] x,
		input logic xe);
		apb(1'h0, a, 32'h00000000);
		chk_word("prdata", x, q);
		chk_bit("pslverr", xe, e);
	endtask

	task automatic settle();
		repeat (6) @(posedge pclk);
	endtask

	task automatic idle();
		int n;
		n = 0;
		while ((cmd_out.run | cmd_out.decel | cmd_out.coast) !== 1'h0
			&& n < 300) begin
			@(posedge pclk);
			n++;
		end
		chk_bit("idle", 1'h1, n < 300);
	endtask

	// Releases the start and times the stop request against the setting
	task automatic stop_check(input logic cm, input logic [15:0] h);
		int n, lo;
		lo = SEC * int'(h >= `SCD_HALT_OFS_MIN ? h - `SCD_HALT_OFS_MIN : h);
		n = 0;
		sw.drive('0);
		while (cmd_out.decel !== 1'h1 && cmd_out.coast !== 1'h1
			&& n < 400) begin
			@(posedge pclk);
			n++;
		end
		chk_bit("coast", cm, cmd_out.coast);
		chk_bit("decel", !cm, cmd_out.decel);
		chk_bit("delay", 1'h1, !cm || (n >= lo && n <= lo + 10));
		idle();
	endtask

	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			give_verdict();
		end
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		foreach (rows[i]) begin
			wr(`SCD_HALT_OFF, {16'h0000, rows[i].halt}, 1'h0);
			t = '0;
			t.fwd = rows[i].fr[1];
			t.rev = rows[i].fr[0];
			sw.drive(t);
			settle();
			chk_bit("run", rows[i].ex[1], cmd_out.run);
			if (rows[i].ex[1]) begin
				chk_bit("dir", rows[i].ex[0], cmd_out.rev);
				stop_check(rows[i].cm, rows[i].halt);
			end
			sw.drive('0);
			idle();
		end
		wr(`SCD_HALT_OFF, 32'h000000C8, 1'h1);
		rd(`SCD_HALT_OFF, 32'h000003EB, 1'h0);
		wr(`SCD_STAT_OFF, 32'h00000001, 1'h1);
		rd(8'hC0, 32'h00000000, 1'h1);
		wr(`SCD_G0SEL_OFF, 32'h0000003C, 1'h1);
		wr(`SCD_HALT_OFF, 32'h0000270F, 1'h0);
		sw.stop_cycles = 20;
		hb = '0;
		hb.hold = 1'h1;
		t = '0;
		t.fwd = 1'h1;
		sw.drive(hb);
		sw.pulse(hb, t);
		settle();
		chk_bit("run", 1'h1, cmd_out.run);
		chk_bit("dir", 1'h0, cmd_out.rev);
		t = '0;
		t.rev = 1'h1;
		sw.pulse(hb, t);
		settle();
		chk_bit("dir", 1'h1, cmd_out.rev);
		rd(`SCD_STAT_OFF, 32'h0000019C, 1'h0);
		t = hb;
		t.shutoff = 1'h1;
		sw.drive(t);
		settle();
		chk_bit("drive_enable", 1'h0, drive_enable);
		sw.drive(hb);
		settle();
		chk_bit("drive_enable", 1'h1, drive_enable);
		chk_bit("run", 1'h1, cmd_out.run);
		sw.drive('0);
		settle();
		chk_bit("run", 1'h0, cmd_out.run);
		chk_bit("decel", 1'h1, cmd_out.decel);
		idle();
		sw.stop_cycles = 3;
		wr(`SCD_CTRL_OFF, 32'h00000001, 1'h0);
		hb.jog = 1'h1;
		t = '0;
		t.fwd = 1'h1;
		sw.drive(hb);
		sw.pulse(hb, t);
		settle();
		chk_bit("run", 1'h0, cmd_out.run);
		sw.drive('0);
		wr(`SCD_CTRL_OFF, 32'h00000000, 1'h0);
		idle();
		wr(`SCD_G0SEL_OFF, 32'h00000019, 1'h0);
		hb = '0;
		hb.gen0 = 1'h1;
		sw.drive(hb);
		sw.pulse(hb, t);
		settle();
		chk_bit("run", 1'h1, cmd_out.run);
		sw.drive('0);
		settle();
		chk_bit("run", 1'h0, cmd_out.run);
		idle();
		wr(`SCD_G1SEL_OFF, 32'h0000003D, 1'h1);
		wr(`SCD_G1SEL_OFF, 32'h00000019, 1'h0);
		hb = '0;
		hb.gen1 = 1'h1;
		sw.drive(hb);
		sw.pulse(hb, t);
		settle();
		chk_bit("run", 1'h1, cmd_out.run);
		sw.drive('0);
		settle();
		chk_bit("run", 1'h0, cmd_out.run);
		idle();
		wr(`SCD_FSEL_OFF, 32'h000000FF, 1'h0);
		sw.drive(t);
		settle();
		chk_bit("run", 1'h0, cmd_out.run);
		sw.drive('0);
		wr(`SCD_FSEL_OFF, 32'h0000003C, 1'h0);
		hb = '0;
		hb.hold = 1'h1;
		sw.drive(hb);
		sw.pulse(hb, t);
		settle();
		@(posedge pclk);
		presetn <= 1'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'h1;
		settle();
		chk_bit("run", 1'h0, cmd_out.run);
		chk_bit("drive_enable", 1'h1, drive_enable);
		rd(`SCD_STAT_OFF, 32'h00000004, 1'h0);
		rd(`SCD_HALT_OFF, 32'h0000270F, 1'h0);
		rd(`SCD_FSEL_OFF, 32'h0000003C, 1'h0);
		rd(`SCD_RSEL_OFF, 32'h0000003D, 1'h0);
		rd(`SCD_G0SEL_OFF, 32'h000000FF, 1'h0);
		rd(`SCD_G1SEL_OFF, 32'h000000FF, 1'h0);
		rd(`SCD_CTRL_OFF, 32'h00000000, 1'h0);
		give_verdict();
	end
endmodule
`default_nettype wire
